//--- hw/ssi_input_stage.sv
// Speed sensor input stage: pin conditioning, tacho edges, encoder clock and direction, APB registers
//
// Contract
// [R1] Tacho mode routes exactly one input, chosen by input_select 00 A, 01 B, 10 C.
// [R2] Tacho edge select 01 rising, 10 falling, 11 both edges make capture events.
// [R3] Software must not use edge select 00 for speed sensing.
// [R4] Unselected inputs in tacho mode are released as general-purpose I/O.
// [R5] Input select writes are preloaded and applied at the next commutation event.
// [R6] With direct access set, a written input select applies immediately.
// [R7] Input select 11 is encoder mode; phased signals arrive on inputs A and B.
// [R8] Encoder mode counts both edges of both inputs, ignoring edge select.
// [R9] Encoder direction flag is read-only and does not steer any counting.
// [R10] Direction flag samples input A on each falling edge of input B.
// [R11] With one encoder channel the encoder clock still runs at half rate.
// [R12] Mode decode: sensor bit and edge select pick position, sensorless or speed mode.
// [R13] Comparator off, edge select nonzero, select 11: all pins GPIO, comparator down.
// [R14] Comparator off, edge select 00, select below 11: comparator on, selected pin analog.
// [R15] Comparator off, edge select 00, select 11: all three pins GPIO.
// [R16] Sensorless: selected pin analog, others Hi-Z or ground per discharge select.
// [R17] Position mode reserves one to three pins as digital inputs, rest GPIO.
// [R18] Speed-sensor mode whenever edge select is not 00; with select 11 and the comparator off the code selects SSI_MODE_NONE instead.
// [R19] Inputs are synchronised, and each qualifying edge gives a one-cycle pulse.
//
// Added by the designer: the register offsets and the APB interface to the registers.
module ssi_input_stage
   import ssi_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic motor_input_a,
   input wire logic motor_input_b,
   input wire logic motor_input_c,
   input wire logic commutation_event,
   output logic capture_pulse,
   output logic encoder_clock_pulse,
   output logic encoder_direction_flag,
   output logic comparator_power_on,
   output logic [2:0] pin_func_a,
   output logic [2:0] pin_func_b,
   output logic [2:0] pin_func_c,
   output logic [4:0] block_mode
);

   function automatic logic [1:0] edges_of(input logic now, input logic old);
      edges_of = {old & ~now, now & ~old};
   endfunction

   function automatic logic [2:0] off_state(input logic off_input_discharge_select);
      off_state = off_input_discharge_select ? SSI_PIN_GND : SSI_PIN_HIZ;
   endfunction

   // Synchronisers: stage one is read only by stage two
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic [2:0] last;
   logic [2:0] next_sync1;
   logic [2:0] next_sync2;
   logic [2:0] next_last;

   always_comb begin
      next_sync1 = {motor_input_c, motor_input_b, motor_input_a};
      next_sync2 = sync1;
      next_last = sync2;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
         last <= 3'h0;
      end else begin
         sync1 <= next_sync1; // [R19]
         sync2 <= next_sync2;
         last <= next_last;
      end
   end

   // Register file
   logic [SSI_CTL_WIDTH-1:0] control;
   logic [1:0] isel_pre;
   logic [1:0] isel_act;
   logic [SSI_CTL_WIDTH-1:0] next_control;
   logic [1:0] next_isel_pre;
   logic [1:0] next_isel_act;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic wr_en;
   logic setup;
   logic mapped;
   logic [31:0] status_word;

   logic [1:0] tes;
   logic sensor;
   logic phase_comparator_off_bit;
   logic off_input_discharge_select;
   logic dac;
   logic allpins;

   always_comb begin
      tes = control[SSI_CTL_TES_LSB +: 2];
      sensor = control[SSI_CTL_SENSOR];
      phase_comparator_off_bit = control[SSI_CTL_PCN];
      off_input_discharge_select = control[SSI_CTL_OFF_INPUT_DISCHARGE_SELECT];
      dac = control[SSI_CTL_DAC];
      allpins = control[SSI_CTL_ALLPINS];
   end

   always_comb begin
      setup = psel & ~penable;
      wr_en = psel & penable & pready & pwrite;
      mapped = (paddr == SSI_OFS_CONTROL) || (paddr == SSI_OFS_INPUT_SELECT) || (paddr == SSI_OFS_STATUS);
      status_word = 32'h0;
      status_word[SSI_STAT_DIR] = encoder_direction_flag; // [R9]
      status_word[SSI_STAT_MODE_LSB +: 5] = block_mode;
      status_word[SSI_STAT_CMP] = comparator_power_on;
      next_control = control;
      next_isel_pre = isel_pre;
      next_isel_act = isel_act;
      if (commutation_event) begin
         next_isel_act = isel_pre; // [R5]
      end
      if (wr_en && paddr == SSI_OFS_CONTROL) begin
         next_control = pwdata[SSI_CTL_WIDTH-1:0];
      end
      if (wr_en && paddr == SSI_OFS_INPUT_SELECT) begin
         next_isel_pre = pwdata[SSI_ISEL_PRE_LSB +: 2]; // [R5]
         if (dac || commutation_event) begin
            next_isel_act = pwdata[SSI_ISEL_PRE_LSB +: 2]; // [R6]
         end
      end
      next_pready = setup;
      next_pslverr = setup & ~mapped;
      next_prdata = 32'h0;
      if (setup && !pwrite) begin
         case (paddr)
            SSI_OFS_CONTROL: begin
               next_prdata[SSI_CTL_WIDTH-1:0] = control;
            end
            SSI_OFS_INPUT_SELECT: begin
               next_prdata[SSI_ISEL_PRE_LSB +: 2] = isel_pre;
               next_prdata[SSI_ISEL_ACT_LSB +: 2] = isel_act;
            end
            SSI_OFS_STATUS: begin
               next_prdata = status_word;
            end
            default: begin
               next_prdata = 32'h0;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control <= SSI_CTL_RESET;
         isel_pre <= SSI_ISEL_RESET;
         isel_act <= SSI_ISEL_RESET;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         control <= next_control;
         isel_pre <= next_isel_pre;
         isel_act <= next_isel_act;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // Mode and pin function decode
   ssi_mode_type mode;
   logic [2:0] func_a;
   logic [2:0] func_b;
   logic [2:0] func_c;
   logic cmp_on;
   logic [2:0] func_sel;
   logic [2:0] func_oth;

   always_comb begin
      mode = SSI_MODE_NONE;
      cmp_on = ~phase_comparator_off_bit | ((tes == SSI_TES_NONE) && (isel_act != SSI_IS_ENC)); // [R14]
      func_sel = SSI_PIN_GPIO;
      func_oth = SSI_PIN_GPIO;
      if (tes != SSI_TES_NONE) begin
         if (isel_act != SSI_IS_ENC) begin
            mode = SSI_MODE_TACHO; // [R18]
            func_sel = SSI_PIN_DIGITAL;
            func_oth = SSI_PIN_GPIO; // [R4]
         end else if (!phase_comparator_off_bit) begin
            mode = SSI_MODE_ENCODER; // [R7]
         end else begin
            mode = SSI_MODE_NONE; // [R13]
         end
      end else if (isel_act == SSI_IS_ENC) begin
         mode = SSI_MODE_NONE; // [R15]
      end else if (phase_comparator_off_bit) begin
         mode = SSI_MODE_NONE;
         func_sel = SSI_PIN_ANALOG; // [R14]
         func_oth = SSI_PIN_GPIO;
      end else if (sensor) begin
         mode = SSI_MODE_POSITION; // [R12]
         func_sel = SSI_PIN_DIGITAL;
         func_oth = allpins ? SSI_PIN_DIGITAL : SSI_PIN_GPIO; // [R17]
      end else begin
         mode = SSI_MODE_SENSORLESS; // [R12]
         func_sel = SSI_PIN_ANALOG; // [R16]
         func_oth = off_state(off_input_discharge_select); // [R16]
      end
      func_a = (isel_act == SSI_IS_A) ? func_sel : func_oth;
      func_b = (isel_act == SSI_IS_B) ? func_sel : func_oth;
      func_c = (isel_act == SSI_IS_C) ? func_sel : func_oth;
      if (mode == SSI_MODE_ENCODER) begin
         func_a = SSI_PIN_DIGITAL;
         func_b = SSI_PIN_DIGITAL;
         func_c = SSI_PIN_GPIO;
      end
      if (mode == SSI_MODE_NONE && isel_act == SSI_IS_ENC) begin
         func_a = SSI_PIN_GPIO; // [R13]
         func_b = SSI_PIN_GPIO;
         func_c = SSI_PIN_GPIO;
      end
   end

   // Edge qualification
   logic [1:0] edge_a;
   logic [1:0] edge_b;
   logic [1:0] edge_c;
   logic [1:0] edge_sel;
   logic next_capture;
   logic next_enc_clk;
   logic next_dir;

   always_comb begin
      edge_a = edges_of(sync2[0], last[0]);
      edge_b = edges_of(sync2[1], last[1]);
      edge_c = edges_of(sync2[2], last[2]);
      case (isel_act)
         SSI_IS_A: begin
            edge_sel = edge_a; // [R1]
         end
         SSI_IS_B: begin
            edge_sel = edge_b; // [R1]
         end
         SSI_IS_C: begin
            edge_sel = edge_c; // [R1]
         end
         default: begin
            edge_sel = 2'h0;
         end
      endcase
      next_capture = 1'b0;
      next_enc_clk = 1'b0;
      next_dir = encoder_direction_flag;
      case (mode)
         SSI_MODE_TACHO: begin
            case (tes)
               SSI_TES_RISE: begin
                  next_capture = edge_sel[0]; // [R2]
               end
               SSI_TES_FALL: begin
                  next_capture = edge_sel[1]; // [R2]
               end
               SSI_TES_BOTH: begin
                  next_capture = |edge_sel; // [R2]
               end
               default: begin
                  next_capture = 1'b0;
               end
            endcase
         end
         SSI_MODE_POSITION: begin
            next_capture = allpins ? (|edge_a | |edge_b | |edge_c) : |edge_sel;
         end
         SSI_MODE_ENCODER: begin
            // A lone channel still toggles the clock on its own edges, so half rate
            next_enc_clk = |edge_a | |edge_b; // [R8] [R11]
            if (edge_b[1]) begin
               next_dir = sync2[0]; // [R10]
            end
         end
         default: begin
            next_capture = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_pulse <= 1'b0;
         encoder_clock_pulse <= 1'b0;
         encoder_direction_flag <= 1'b0;
         comparator_power_on <= 1'b1;
         pin_func_a <= SSI_PIN_GPIO;
         pin_func_b <= SSI_PIN_GPIO;
         pin_func_c <= SSI_PIN_GPIO;
         block_mode <= SSI_MODE_NONE;
      end else begin
         capture_pulse <= next_capture; // [R19]
         encoder_clock_pulse <= next_enc_clk; // [R19]
         encoder_direction_flag <= next_dir;
         comparator_power_on <= cmp_on; // [R13]
         pin_func_a <= func_a;
         pin_func_b <= func_b;
         pin_func_c <= func_c;
         block_mode <= mode;
      end
   end

endmodule

//--- hw/ssi_pkg.sv
// Constants and types shared by the speed sensor input stage
package ssi_pkg;
   localparam logic [7:0] SSI_OFS_CONTROL = 8'h00;
   localparam logic [7:0] SSI_OFS_INPUT_SELECT = 8'h04;
   localparam logic [7:0] SSI_OFS_STATUS = 8'h08;

   localparam int SSI_CTL_TES_LSB = 0;
   localparam int SSI_CTL_SENSOR = 2;
   localparam int SSI_CTL_PCN = 3;
   localparam int SSI_CTL_OFF_INPUT_DISCHARGE_SELECT = 4;
   localparam int SSI_CTL_DAC = 5;
   localparam int SSI_CTL_ALLPINS = 6;
   localparam int SSI_CTL_WIDTH = 7;
   localparam logic [SSI_CTL_WIDTH-1:0] SSI_CTL_RESET = 7'h00;

   localparam int SSI_ISEL_PRE_LSB = 0;
   localparam int SSI_ISEL_ACT_LSB = 2;
   localparam logic [1:0] SSI_ISEL_RESET = 2'h0;

   localparam int SSI_STAT_DIR = 0;
   localparam int SSI_STAT_MODE_LSB = 1;
   localparam int SSI_STAT_CMP = 6;

   localparam logic [1:0] SSI_IS_A = 2'h0;
   localparam logic [1:0] SSI_IS_B = 2'h1;
   localparam logic [1:0] SSI_IS_C = 2'h2;
   localparam logic [1:0] SSI_IS_ENC = 2'h3;

   localparam logic [1:0] SSI_TES_NONE = 2'h0;
   localparam logic [1:0] SSI_TES_RISE = 2'h1;
   localparam logic [1:0] SSI_TES_FALL = 2'h2;
   localparam logic [1:0] SSI_TES_BOTH = 2'h3;

   typedef enum logic [4:0] {
      SSI_MODE_NONE = 5'b00001,
      SSI_MODE_SENSORLESS = 5'b00010,
      SSI_MODE_POSITION = 5'b00100,
      SSI_MODE_TACHO = 5'b01000,
      SSI_MODE_ENCODER = 5'b10000
   } ssi_mode_type;

   typedef enum logic [2:0] {
      SSI_PIN_GPIO = 3'h0,
      SSI_PIN_DIGITAL = 3'h1,
      SSI_PIN_ANALOG = 3'h2,
      SSI_PIN_HIZ = 3'h3,
      SSI_PIN_GND = 3'h4
   } ssi_pin_type;
endpackage

//--- test/ssi_sensor_model.sv
// Sensor model driving the three motor input pins
module ssi_sensor_model (
   input wire logic pclk,
   output logic motor_input_a,
   output logic motor_input_b,
   output logic motor_input_c
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {motor_input_a, motor_input_b, motor_input_c} = 3'h0;
   // Slow edges give the two-flop synchroniser time to settle
   task automatic flip(input int idx);
      @(posedge pclk);
      case (idx)
         0: motor_input_a <= ~motor_input_a;
         1: motor_input_b <= ~motor_input_b;
         default: motor_input_c <= ~motor_input_c;
      endcase
      repeat (8) @(posedge pclk);
   endtask
   // Quarter steps of a pair phased by 90 degrees on A and B
   task automatic quad(input logic fwd, input int n);
      for (int i = 0; i < n; i++) begin
         flip((fwd ^ motor_input_a ^ motor_input_b) ? 0 : 1);
      end
   endtask
endmodule

//--- test/ssi_input_stage_checker.sv
// Port assertions for the speed sensor input stage
module ssi_input_stage_checker
   import ssi_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic capture_pulse,
   input wire logic encoder_clock_pulse,
   input wire logic encoder_direction_flag,
   input wire logic comparator_power_on,
   input wire logic [2:0] pin_func_a,
   input wire logic [2:0] pin_func_b,
   input wire logic [2:0] pin_func_c,
   input wire logic [4:0] block_mode
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence answer_s;
      psel && penable && pready;
   endsequence
   ready_setup_a: assert property (setup_s |=> answer_s)
      else $error("no answer after setup");
   ready_single_a: assert property (pready |=> !pready)
      else $error("pready held");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata outside access");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr alone");
   cap_mode_a: assert property (capture_pulse |-> block_mode inside {SSI_MODE_POSITION, SSI_MODE_TACHO})
      else $error("capture in wrong mode");
   cap_single_a: assert property (capture_pulse |=> !capture_pulse)
      else $error("capture pulse too long");
   enc_mode_a: assert property (encoder_clock_pulse |-> block_mode == SSI_MODE_ENCODER)
      else $error("encoder clock in wrong mode");
   dir_step_a: assert property ($changed(encoder_direction_flag) |-> encoder_clock_pulse)
      else $error("direction moved without edge");
   // Tacho with the comparator off keeps its selected pin digital, so only the released case is checked
   off_gpio_a: assert property ((!comparator_power_on && block_mode == SSI_MODE_NONE)
      |-> {pin_func_a, pin_func_b, pin_func_c} == 9'h0)
      else $error("pins not released");
endmodule

//--- test/ssi_input_stage_tb_top.sv
// Self-checking testbench for the speed sensor input stage
module ssi_input_stage_tb_top
   import ssi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic commutation_event = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, capture_pulse, encoder_clock_pulse, encoder_direction_flag, comparator_power_on;
   logic motor_input_a, motor_input_b, motor_input_c;
   logic [2:0] pin_func_a, pin_func_b, pin_func_c;
   logic [4:0] block_mode;
   int bad_count = 0;
   int cmp_count = 0;
   int caps = 0;
   int encs = 0;
   int c0, e0;
`define SSI_CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin bad_count++; \
   $display("wrong value at %0t: got %0h expected %0h", $time, g, x); end end
   ssi_input_stage ssi_input_stage_inst (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .motor_input_a(motor_input_a),
      .motor_input_b(motor_input_b),
      .motor_input_c(motor_input_c),
      .commutation_event(commutation_event),
      .capture_pulse(capture_pulse),
      .encoder_clock_pulse(encoder_clock_pulse),
      .encoder_direction_flag(encoder_direction_flag),
      .comparator_power_on(comparator_power_on),
      .pin_func_a(pin_func_a),
      .pin_func_b(pin_func_b),
      .pin_func_c(pin_func_c),
      .block_mode(block_mode)
   );
   ssi_sensor_model ssi_sensor_model_inst (
      .pclk(pclk),
      .motor_input_a(motor_input_a),
      .motor_input_b(motor_input_b),
      .motor_input_c(motor_input_c)
   );
   always #12.5 pclk = ~pclk;
   always @(posedge pclk) begin
      caps <= caps + int'(capture_pulse);
      encs <= encs + int'(encoder_clock_pulse);
   end
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Zero wait states expected, but the master waits for pready under a bound
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         bad_count++;
         final_report();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      repeat (2) @(posedge pclk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      `SSI_CHK({e, r}, {1'b0, x})
   endtask
   function automatic logic [2:0] pf(input int i);
      return (i == 0) ? pin_func_a : (i == 1) ? pin_func_b : pin_func_c;
   endfunction
   task automatic flips(input int idx, input int n);
      c0 = caps;
      e0 = encs;
      for (int i = 0; i < n; i++) ssi_sensor_model_inst.flip(idx);
   endtask
   task automatic t_reset();
      logic [31:0] r;
      logic e;
      rd_chk(SSI_OFS_STATUS, 32'h44);
      `SSI_CHK({pin_func_a, pin_func_b}, {SSI_PIN_ANALOG, SSI_PIN_HIZ})
      wr(SSI_OFS_CONTROL, 32'h10);
      `SSI_CHK(pin_func_c, SSI_PIN_GND)
      apb(1'b0, 8'h0C, 32'h0, r, e);
      `SSI_CHK({e, r}, 33'h100000000)
      $display("reset test done");
   endtask
   task automatic t_select();
      wr(SSI_OFS_CONTROL, 32'h01);
      wr(SSI_OFS_INPUT_SELECT, 32'h1);
      rd_chk(SSI_OFS_INPUT_SELECT, 32'h1);
      commutation_event <= 1'b1;
      @(posedge pclk);
      commutation_event <= 1'b0;
      rd_chk(SSI_OFS_INPUT_SELECT, 32'h5);
      wr(SSI_OFS_CONTROL, 32'h21);
      wr(SSI_OFS_INPUT_SELECT, 32'h2);
      rd_chk(SSI_OFS_INPUT_SELECT, 32'hA);
      $display("select test done");
   endtask
   task automatic t_tacho();
      for (int s = 0; s < 3; s++) begin
         for (int t = 1; t < 4; t++) begin
            wr(SSI_OFS_CONTROL, 32'h20 | t);
            wr(SSI_OFS_INPUT_SELECT, s);
            `SSI_CHK(block_mode, SSI_MODE_TACHO)
            `SSI_CHK(pf(s), SSI_PIN_DIGITAL)
            `SSI_CHK(pf((s + 1) % 3), SSI_PIN_GPIO)
            flips(s, 2);
            `SSI_CHK(caps - c0, (t == 3) ? 2 : 1)
            flips((s + 2) % 3, 2);
            `SSI_CHK(caps - c0, 0)
         end
      end
      $display("tacho test done");
   endtask
   task automatic t_encoder();
      wr(SSI_OFS_CONTROL, 32'h21);
      wr(SSI_OFS_INPUT_SELECT, 32'h3);
      `SSI_CHK(block_mode, SSI_MODE_ENCODER)
      e0 = encs;
      ssi_sensor_model_inst.quad(1'b1, 8);
      `SSI_CHK(encs - e0, 8)
      `SSI_CHK(encoder_direction_flag, 1'b0)
      ssi_sensor_model_inst.quad(1'b0, 8);
      wr(SSI_OFS_STATUS, 32'h0);
      `SSI_CHK(encoder_direction_flag, 1'b1)
      flips(1, 4);
      `SSI_CHK(encs - e0, 4)
      `SSI_CHK(encoder_direction_flag, 1'b0)
      $display("encoder test done");
   endtask
   task automatic t_pins();
      wr(SSI_OFS_CONTROL, 32'h29);
      `SSI_CHK({comparator_power_on, pf(0), pf(1), pf(2)}, 10'h0)
      flips(0, 2);
      `SSI_CHK(encs - e0 + caps - c0, 0)
      wr(SSI_OFS_CONTROL, 32'h28);
      `SSI_CHK({pf(0), pf(2)}, 6'h0)
      wr(SSI_OFS_CONTROL, 32'h29);
      wr(SSI_OFS_INPUT_SELECT, 32'h0);
      wr(SSI_OFS_CONTROL, 32'h28);
      `SSI_CHK({comparator_power_on, pin_func_a}, {1'b1, SSI_PIN_ANALOG})
      wr(SSI_OFS_CONTROL, 32'h24);
      wr(SSI_OFS_INPUT_SELECT, 32'h1);
      `SSI_CHK({block_mode, pin_func_b, pin_func_c}, {SSI_MODE_POSITION, SSI_PIN_DIGITAL, SSI_PIN_GPIO})
      flips(1, 2);
      `SSI_CHK(caps - c0, 2)
      wr(SSI_OFS_CONTROL, 32'h64);
      `SSI_CHK(pin_func_c, SSI_PIN_DIGITAL)
      flips(2, 2);
      `SSI_CHK(caps - c0, 2)
      $display("pin test done");
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_select();
      t_tacho();
      t_encoder();
      t_pins();
      final_report();
   end
endmodule
bind ssi_input_stage ssi_input_stage_checker ssi_input_stage_checker_inst (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .capture_pulse(capture_pulse),
   .encoder_clock_pulse(encoder_clock_pulse),
   .encoder_direction_flag(encoder_direction_flag),
   .comparator_power_on(comparator_power_on),
   .pin_func_a(pin_func_a),
   .pin_func_b(pin_func_b),
   .pin_func_c(pin_func_c),
   .block_mode(block_mode)
);
